/* design/eqlc_defs.svh */
// Offsets, field positions, masks and reset values of the equalizer,
// loudness and crossover control registers.
// Assumes it is included once per compile unit by its bare name.
// How it works
// - Band code 0..6 picks 120..12000 Hz.
// - Gain code steps 0.5 dB, 24 is 0 dB.
// - Reset values 0x0018, 0x0000, 0x0505.
// - Loudness cutoff codes pick 10/30/50/70 Hz.
// - Loudness level is 1 dB per code, 0..15.
// - Low crossover is 50 Hz plus 10 Hz/code.
// - Low crossover drives woofer low-pass cutoff.
// - High crossover is 50 Hz plus 10 Hz/code.
// - High crossover drives tweeter high-pass cutoff.
// - Control port reaches registers, pointer auto-increments.
`ifndef EQLC_DEFS_SVH
`define EQLC_DEFS_SVH

`define EQLC_ADDR_EQ 16'h0107
`define EQLC_ADDR_LOUD 16'h0108
`define EQLC_ADDR_XOVER 16'h0109

`define EQLC_RST_EQ 16'h0018
`define EQLC_RST_LOUD 16'h0000
`define EQLC_RST_XOVER 16'h0505

`define EQLC_MASK_EQ 16'h073f
`define EQLC_MASK_LOUD 16'h007f
`define EQLC_MASK_XOVER 16'h3f3f

`define EQLC_EQ_BAND_LSB 8
`define EQLC_EQ_GAIN_LSB 0
`define EQLC_LOUD_CUT_LSB 5
`define EQLC_LOUD_LVL_LSB 0
`define EQLC_XO_LOW_LSB 8
`define EQLC_XO_HIGH_LSB 0

`define EQLC_GAIN_ZERO_CODE 6'h18
`define EQLC_GAIN_MAX_CODE 6'h30
`define EQLC_LVL_MAX_CODE 5'h0f
`define EQLC_XO_LOW_MAX_CODE 6'h2e
`define EQLC_XO_HIGH_MAX_CODE 6'h3c
`define EQLC_XO_BASE_HZ 10'h032

`endif

/* design/eqlc_pkg.sv */
// Types shared by the equalizer, loudness and crossover register bank.
// Assumes nothing of its surroundings.
`default_nettype none
package eqlc_pkg;
  typedef enum logic [2:0] {
    EQLC_BAND_120,
    EQLC_BAND_200,
    EQLC_BAND_500,
    EQLC_BAND_1200,
    EQLC_BAND_3000,
    EQLC_BAND_7500,
    EQLC_BAND_12000,
    EQLC_BAND_RSVD
  } eqlc_band_e;
  typedef enum logic [1:0] {
    EQLC_ACC_IDLE,
    EQLC_ACC_WRITE,
    EQLC_ACC_READ,
    EQLC_ACC_LOAD
  } eqlc_acc_e;
  typedef logic [15:0] eqlc_word_t;
endpackage
`default_nettype wire

/* design/eqlc_regs.sv */
// Register bank for the main equalizer, loudness and crossover settings,
// with decoded settings for the audio datapath.
// Assumes a control-port engine on the same clock that loads the address
// pointer, then presents one data word per write or read strobe.
`include "eqlc_defs.svh"
`default_nettype none
module eqlc_regs (
  input wire logic SYS_CLK_I,
  input wire logic NRST_I,
  input wire logic PTR_LOAD_I,
  input wire logic [15:0] PTR_I,
  input wire logic WR_EN_I,
  input wire logic [15:0] WR_DATA_I,
  input wire logic RD_EN_I,
  output logic [15:0] RD_DATA_O,
  output logic RD_VALID_O,
  output logic [15:0] PTR_O,
  output logic [15:0] EQ_REG_O,
  output logic [15:0] LOUD_REG_O,
  output logic [15:0] XOVER_REG_O,
  output eqlc_pkg::eqlc_band_e EQ_BAND_O,
  output logic [13:0] EQ_BAND_HZ_O,
  output logic signed [6:0] EQ_GAIN_HALF_DB_O,
  output logic [6:0] LOUD_CUT_HZ_O,
  output logic [4:0] LOUD_LEVEL_DB_O,
  output logic [9:0] WOOFER_LPF_HZ_O,
  output logic [9:0] TWEETER_HPF_HZ_O,
  output logic [4:0] RSVD_CODE_O,
  output logic CFG_CHANGE_O
);

  // Only one access per cycle: a pointer load beats a write, a write beats
  // a read. The engine never issues two at once, so this is only a guard.
  eqlc_pkg::eqlc_acc_e acc;
  logic [15:0] ptr_q;
  logic [15:0] ptr_d;
  logic [15:0] eq_q;
  logic [15:0] eq_d;
  logic [15:0] loud_q;
  logic [15:0] loud_d;
  logic [15:0] xo_q;
  logic [15:0] xo_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic rvalid_q;
  logic change_q;
  logic change_d;

  wire hit_eq = (ptr_q == `EQLC_ADDR_EQ);
  wire hit_loud = (ptr_q == `EQLC_ADDR_LOUD);
  wire hit_xo = (ptr_q == `EQLC_ADDR_XOVER);
  wire do_wr = (acc == eqlc_pkg::EQLC_ACC_WRITE);
  wire do_rd = (acc == eqlc_pkg::EQLC_ACC_READ);

  always_comb begin
    if (PTR_LOAD_I) begin
      acc = eqlc_pkg::EQLC_ACC_LOAD;
    end else if (WR_EN_I) begin
      acc = eqlc_pkg::EQLC_ACC_WRITE;
    end else if (RD_EN_I) begin
      acc = eqlc_pkg::EQLC_ACC_READ;
    end else begin
      acc = eqlc_pkg::EQLC_ACC_IDLE;
    end
  end

  // The pointer steps after each data word so a block transfer walks
  // through consecutive registers; it wraps at the top of the space.
  always_comb begin
    case (acc)
      eqlc_pkg::EQLC_ACC_LOAD: ptr_d = PTR_I;
      eqlc_pkg::EQLC_ACC_WRITE: ptr_d = ptr_q + 16'h0001;
      eqlc_pkg::EQLC_ACC_READ: ptr_d = ptr_q + 16'h0001;
      default: ptr_d = ptr_q;
    endcase
  end

  // Reserved bits are masked off on the way in, so they always read zero
  // even if the host breaks its promise to write them as zero.
  wire [15:0] wr_eq = WR_DATA_I & `EQLC_MASK_EQ;
  wire [15:0] wr_loud = WR_DATA_I & `EQLC_MASK_LOUD;
  wire [15:0] wr_xo = WR_DATA_I & `EQLC_MASK_XOVER;

  assign eq_d = (do_wr && hit_eq) ? wr_eq : eq_q;
  assign loud_d = (do_wr && hit_loud) ? wr_loud : loud_q;
  assign xo_d = (do_wr && hit_xo) ? wr_xo : xo_q;
  assign change_d = (eq_d != eq_q) || (loud_d != loud_q) ||
                    (xo_d != xo_q);

  // Unmapped addresses read as zero and swallow writes.
  always_comb begin
    rdata_d = rdata_q;
    if (do_rd) begin
      if (hit_eq) begin
        rdata_d = eq_q;
      end else if (hit_loud) begin
        rdata_d = loud_q;
      end else if (hit_xo) begin
        rdata_d = xo_q;
      end else begin
        rdata_d = 16'h0000;
      end
    end
  end

  // One register per process keeps each reset value beside its flop.
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      ptr_q <= 16'h0000;
    end else begin
      ptr_q <= ptr_d;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      eq_q <= `EQLC_RST_EQ;
    end else begin
      eq_q <= eq_d;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      loud_q <= `EQLC_RST_LOUD;
    end else begin
      loud_q <= loud_d;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      xo_q <= `EQLC_RST_XOVER;
    end else begin
      xo_q <= xo_d;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= do_rd;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      change_q <= 1'b0;
    end else begin
      change_q <= change_d;
    end
  end

  // Field extraction.
  wire [2:0] band_c = eq_q[`EQLC_EQ_BAND_LSB +: 3];
  wire [5:0] gain_c = eq_q[`EQLC_EQ_GAIN_LSB +: 6];
  wire [1:0] cut_c = loud_q[`EQLC_LOUD_CUT_LSB +: 2];
  wire [4:0] lvl_c = loud_q[`EQLC_LOUD_LVL_LSB +: 5];
  wire [5:0] low_c = xo_q[`EQLC_XO_LOW_LSB +: 6];
  wire [5:0] high_c = xo_q[`EQLC_XO_HIGH_LSB +: 6];

  logic [13:0] band_hz;
  always_comb begin
    case (band_c)
      3'h0: band_hz = 14'd120;
      3'h1: band_hz = 14'd200;
      3'h2: band_hz = 14'd500;
      3'h3: band_hz = 14'd1200;
      3'h4: band_hz = 14'd3000;
      3'h5: band_hz = 14'd7500;
      3'h6: band_hz = 14'd12000;
      default: band_hz = 14'd0;
    endcase
  end

  logic [6:0] cut_hz;
  always_comb begin
    case (cut_c)
      2'h0: cut_hz = 7'd10;
      2'h1: cut_hz = 7'd30;
      2'h2: cut_hz = 7'd50;
      default: cut_hz = 7'd70;
    endcase
  end

  // Gain falls half a decibel per code from +24 half-steps at code 0.
  wire signed [6:0] gain_half =
    $signed({1'b0, `EQLC_GAIN_ZERO_CODE}) - $signed({1'b0, gain_c});

  // Crossover corners are 50 Hz plus ten times the code.
  wire [9:0] low_hz = `EQLC_XO_BASE_HZ + {1'b0, low_c, 3'b000} +
                      {3'b000, low_c, 1'b0};
  wire [9:0] high_hz = `EQLC_XO_BASE_HZ + {1'b0, high_c, 3'b000} +
                       {3'b000, high_c, 1'b0};

  // Out-of-range codes still pass through the decode unchanged; the
  // datapath sees the flags and may hold its last good setting.
  wire [4:0] rsvd = {
    (high_c > `EQLC_XO_HIGH_MAX_CODE),
    (low_c > `EQLC_XO_LOW_MAX_CODE),
    (lvl_c > `EQLC_LVL_MAX_CODE),
    (gain_c > `EQLC_GAIN_MAX_CODE),
    (band_c == 3'h7)
  };

  logic [13:0] band_hz_q;
  logic [2:0] band_q;
  logic signed [6:0] gain_half_q;
  logic [6:0] cut_hz_q;
  logic [4:0] lvl_q;
  logic [9:0] lpf_q;
  logic [9:0] hpf_q;
  logic [4:0] rsvd_q;

  // The decoded settings lag the stored words by one cycle, which keeps
  // the adders and tables off the datapath's timing path.
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      band_q <= 3'h0;
    end else begin
      band_q <= band_c;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      band_hz_q <= 14'h0078;
    end else begin
      band_hz_q <= band_hz;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      gain_half_q <= 7'sh00;
    end else begin
      gain_half_q <= gain_half;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      cut_hz_q <= 7'h0a;
    end else begin
      cut_hz_q <= cut_hz;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      lvl_q <= 5'h00;
    end else begin
      lvl_q <= lvl_c;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      lpf_q <= 10'h064;
    end else begin
      lpf_q <= low_hz;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      hpf_q <= 10'h064;
    end else begin
      hpf_q <= high_hz;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      rsvd_q <= 5'h00;
    end else begin
      rsvd_q <= rsvd;
    end
  end

  assign RD_DATA_O = rdata_q;
  assign RD_VALID_O = rvalid_q;
  assign PTR_O = ptr_q;
  assign EQ_REG_O = eq_q;
  assign LOUD_REG_O = loud_q;
  assign XOVER_REG_O = xo_q;
  assign EQ_BAND_O = eqlc_pkg::eqlc_band_e'(band_q);
  assign EQ_BAND_HZ_O = band_hz_q;
  assign EQ_GAIN_HALF_DB_O = gain_half_q;
  assign LOUD_CUT_HZ_O = cut_hz_q;
  assign LOUD_LEVEL_DB_O = lvl_q;
  assign WOOFER_LPF_HZ_O = lpf_q;
  assign TWEETER_HPF_HZ_O = hpf_q;
  assign RSVD_CODE_O = rsvd_q;
  assign CFG_CHANGE_O = change_q;

endmodule
`default_nettype wire

/* tb/eqlc_host.sv */
// Host model that drives the register access port of the bank.
// Assumes one access per clock, launched just after a rising edge.
`default_nettype none
module eqlc_host (
  input wire logic clk_i,
  output logic ld_o,
  output logic [15:0] ptr_o,
  output logic we_o,
  output logic [15:0] wd_o,
  output logic re_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] p;
  initial {ld_o, ptr_o, we_o, wd_o, re_o, p} = '0;
  task op(input logic l, w, r, input logic [15:0] v);
    @(posedge clk_i);
    ld_o <= l;
    we_o <= w;
    re_o <= r;
    ptr_o <= l ? v : ptr_o;
    // The pointer is tracked here so reserved bits go out as zero.
    wd_o <= v & (p == 16'h0107 ? 16'h073f : p == 16'h0108 ? 16'h007f :
      p == 16'h0109 ? 16'h3f3f : 16'hffff);
    p = l ? v : p + {15'h0, w | r};
  endtask
endmodule
`default_nettype wire

/* tb/eqlc_regs_props.sv */
// Checker for the equalizer, loudness and crossover register bank.
// Assumes it is bound to eqlc_regs and sees only its ports.
`default_nettype none
module eqlc_regs_props (
  input wire logic SYS_CLK_I,
  input wire logic NRST_I,
  input wire logic PTR_LOAD_I,
  input wire logic [15:0] PTR_I,
  input wire logic WR_EN_I,
  input wire logic [15:0] WR_DATA_I,
  input wire logic RD_EN_I,
  input wire logic RD_VALID_O,
  input wire logic [15:0] PTR_O,
  input wire logic [15:0] EQ_REG_O,
  input wire logic [15:0] LOUD_REG_O,
  input wire logic [15:0] XOVER_REG_O,
  input wire logic [13:0] EQ_BAND_HZ_O,
  input wire logic signed [6:0] EQ_GAIN_HALF_DB_O,
  input wire logic [6:0] LOUD_CUT_HZ_O,
  input wire logic [9:0] WOOFER_LPF_HZ_O,
  input wire logic [9:0] TWEETER_HPF_HZ_O,
  input wire logic [4:0] RSVD_CODE_O,
  input wire logic [2:0] EQ_BAND_O,
  input wire logic [4:0] LOUD_LEVEL_DB_O,
  input wire logic CFG_CHANGE_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!NRST_I);
  localparam logic [13:0] HZ [8] = '{14'h78, 14'hc8, 14'h1f4, 14'h4b0,
    14'hbb8, 14'h1d4c, 14'h2ee0, 14'h0};
  chk_band_hz: assert property (EQ_BAND_HZ_O ==
    HZ[$past(EQ_REG_O[10:8])]) else $error("bad band");
  chk_gain_half: assert property (EQ_GAIN_HALF_DB_O ==
    7'(7'h18 - $past(EQ_REG_O[5:0]))) else $error("bad gain");
  chk_loud_cut: assert property (LOUD_CUT_HZ_O ==
    7'h0a + 7'h14 * $past(LOUD_REG_O[6:5])) else $error("bad cutoff");
  chk_woofer_lpf: assert property (WOOFER_LPF_HZ_O ==
    10'h32 + 10'h0a * $past(XOVER_REG_O[13:8])) else $error("bad low");
  chk_tweeter_hpf: assert property (TWEETER_HPF_HZ_O ==
    10'h32 + 10'h0a * $past(XOVER_REG_O[5:0])) else $error("bad high");
  chk_rsvd_flags: assert property (RSVD_CODE_O[1:0] ==
    {$past(EQ_REG_O[5:0]) > 6'h30, $past(EQ_REG_O[10:8]) == 3'h7})
    else $error("bad reserved flags");
  chk_reset_vals: assert property (disable iff (1'b0) !NRST_I |=>
    {EQ_REG_O, LOUD_REG_O, XOVER_REG_O} == 48'h0018_0000_0505)
    else $error("bad reset value");
  chk_eq_write: assert property (WR_EN_I && !PTR_LOAD_I &&
    PTR_O == 16'h0107 |=> EQ_REG_O == $past(WR_DATA_I & 16'h073f))
    else $error("bad write");
  chk_ptr_load: assert property (PTR_LOAD_I |=>
    PTR_O == $past(PTR_I)) else $error("bad pointer load");
  chk_ptr_step: assert property ((WR_EN_I || RD_EN_I) &&
    !PTR_LOAD_I |=> PTR_O == $past(PTR_O) + 16'h1) else $error("no step");
  chk_rd_valid: assert property (RD_VALID_O ==
    $past(RD_EN_I && !PTR_LOAD_I && !WR_EN_I)) else $error("bad valid");
  chk_band_code: assert property (EQ_BAND_O ==
    $past(EQ_REG_O[10:8])) else $error("bad band code");
  chk_loud_level: assert property (LOUD_LEVEL_DB_O ==
    $past(LOUD_REG_O[4:0])) else $error("bad level");
  chk_rsvd_upper: assert property (RSVD_CODE_O[4:2] ==
    {$past(XOVER_REG_O[5:0]) > 6'h3c, $past(XOVER_REG_O[13:8]) > 6'h2e,
    $past(LOUD_REG_O[4:0]) > 5'h0f}) else $error("bad range flags");
  chk_cfg_change: assert property (CFG_CHANGE_O ==
    ({EQ_REG_O, LOUD_REG_O, XOVER_REG_O} !=
    $past({EQ_REG_O, LOUD_REG_O, XOVER_REG_O}))) else $error("bad change");
endmodule
bind eqlc_regs eqlc_regs_props chk_u (.SYS_CLK_I, .NRST_I, .PTR_LOAD_I,
  .PTR_I, .WR_EN_I, .WR_DATA_I, .RD_EN_I, .RD_VALID_O, .PTR_O, .EQ_REG_O,
  .LOUD_REG_O, .XOVER_REG_O, .EQ_BAND_HZ_O, .EQ_GAIN_HALF_DB_O,
  .LOUD_CUT_HZ_O, .WOOFER_LPF_HZ_O, .TWEETER_HPF_HZ_O, .RSVD_CODE_O,
  .EQ_BAND_O(EQ_BAND_O), .LOUD_LEVEL_DB_O, .CFG_CHANGE_O);
`default_nettype wire

/* tb/test_eqlc_regs.sv */
// Self-checking bench for the register bank driven by the host model.
// Assumes the checker is bound to the bank from its own file.
`default_nettype none
module test_eqlc_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] m [3];
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  wire logic ld, we, re, rdv;
  wire logic [15:0] pi, wd, rdd;
  wire logic [9:0] lpf, hpf;
  wire logic [4:0] lvl;
  wire logic signed [6:0] gn;
  always #50 clk = ~clk;
  eqlc_host host_u (.clk_i(clk), .ld_o(ld), .ptr_o(pi), .we_o(we),
    .wd_o(wd), .re_o(re));
  eqlc_regs dut_u (.SYS_CLK_I(clk), .NRST_I(nrst), .PTR_LOAD_I(ld),
    .PTR_I(pi), .WR_EN_I(we), .WR_DATA_I(wd), .RD_EN_I(re),
    .RD_DATA_O(rdd), .RD_VALID_O(rdv), .PTR_O(), .EQ_REG_O(),
    .LOUD_REG_O(), .XOVER_REG_O(), .EQ_BAND_O(), .EQ_BAND_HZ_O(),
    .EQ_GAIN_HALF_DB_O(gn), .LOUD_CUT_HZ_O(), .LOUD_LEVEL_DB_O(lvl),
    .WOOFER_LPF_HZ_O(lpf), .TWEETER_HPF_HZ_O(hpf), .RSVD_CODE_O(),
    .CFG_CHANGE_O());
  function automatic logic [15:0] ev(input logic [15:0] a);
    return (a > 16'h0106 && a < 16'h010a) ? m[a - 16'h0107] : 16'h0;
  endfunction
  task cmp(input logic [15:0] g, e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %0t %h %h", $time, g, e);
    end
  endtask
  task give_verdict();
    if (fail_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Unmapped places on both sides are read to catch a stray decode.
  task rd_all();
    host_u.op(1'b1, 1'b0, 1'b0, 16'h0106);
    for (int a = 16'h0106; a < 16'h010b; a++) begin
      host_u.op(1'b0, 1'b0, 1'b1, 16'h0);
      host_u.op(1'b0, 1'b0, 1'b0, 16'h0);
      #1;
      cmp({15'h0, rdv}, 16'h1);
      cmp(rdd, ev(16'(a)));
    end
    cmp({6'h0, lpf}, 16'h32 + 16'h0a * m[2][13:8]);
    cmp({6'h0, hpf}, 16'h32 + 16'h0a * m[2][5:0]);
    cmp({11'h0, lvl}, {11'h0, m[1][4:0]});
    cmp({{9{gn[6]}}, gn}, 16'h18 - m[0][5:0]);
  endtask
  task wr_all(input logic [15:0] d0, d1, d2);
    host_u.op(1'b1, 1'b0, 1'b0, 16'h0107);
    host_u.op(1'b0, 1'b1, 1'b0, d0);
    host_u.op(1'b0, 1'b1, 1'b0, d1);
    host_u.op(1'b0, 1'b1, 1'b0, d2);
    host_u.op(1'b0, 1'b0, 1'b0, 16'h0);
    m = '{d0 & 16'h073f, d1 & 16'h007f, d2 & 16'h3f3f};
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(29));
    m = '{16'h0018, 16'h0000, 16'h0505};
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rd_all();
    // Every band and cutoff code, with the top codes running past range in the band, gain and both crossover fields.
    for (int i = 0; i < 8; i++) begin
      wr_all({5'h0, 3'(i), 2'h0, 6'(i * 7)}, {9'h0, 2'(i), 5'(i * 2)},
        {2'h0, 6'(i * 7), 2'h0, 6'(i * 9)});
      rd_all();
    end
    repeat (8) begin
      wr_all(16'($urandom), 16'($urandom), 16'($urandom));
      rd_all();
    end
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    m = '{16'h0018, 16'h0000, 16'h0505};
    rd_all();
    give_verdict();
  end
endmodule
`default_nettype wire
